// file: rtl/drive_protection_trip_control.sv
`timescale 1ns/1ps
`default_nettype none
module drive_protection_trip_control #(
    parameter int unsigned TICK_CYCLES = prot_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins from the controller and the power stage
    input wire logic [prot_pkg::N_TERMINALS-1:0] input_terminal,
    input wire logic run_command,
    input wire logic keypad_stop_reset,
    input wire logic fan_error,
    input wire logic dc_undervoltage,
    input wire logic over_temperature,
    // configuration
    input wire logic fan_fault_mode,
    input wire logic [prot_pkg::N_TERMINALS*prot_pkg::FN_W-1:0] input_terminal_function,
    input wire logic [2*prot_pkg::FN_W-1:0] relay_output_function,
    input wire logic [prot_pkg::FN_W-1:0] transistor_output_function,
    input wire logic [prot_pkg::TIME_W-1:0] undervoltage_trip_delay,
    input wire logic [prot_pkg::TIME_W-1:0] block_stop_time,
    // live values from the control path
    input wire logic [prot_pkg::MON_W-1:0] output_frequency,
    input wire logic [prot_pkg::MON_W-1:0] output_current,
    // power stage control
    output logic power_enable,
    output logic decelerating,
    // indications and multi-function outputs
    output logic block_indication,
    output logic [prot_pkg::MON_W-1:0] held_frequency,
    output logic [prot_pkg::MON_W-1:0] held_current,
    output logic [1:0] relay_out,
    output logic transistor_out,
    output logic fan_trip,
    output logic undervoltage_trip,
    output logic overheat_trip
);

    localparam int unsigned SYNC_W = prot_pkg::N_TERMINALS + 5;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [SYNC_W-1:0] meta_q, sync_q;
    logic [prot_pkg::N_TERMINALS-1:0] term_s;
    logic run_s, key_s, fan_s, uv_s, hot_s;

    // only the second stage is read by logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {run_command, keypad_stop_reset, fan_error, dc_undervoltage,
                       over_temperature, input_terminal};
            sync_q <= meta_q;
        end
    end

    assign {run_s, key_s, fan_s, uv_s, hot_s, term_s} = sync_q;

    // ----------------------------------------------------------------
    // terminal decode
    // ----------------------------------------------------------------
    logic [prot_pkg::N_TERMINALS-1:0] reset_hit, block_hit;
    logic reset_level, block_in;

    for (genvar i = 0; i < prot_pkg::N_TERMINALS; i++) begin : g_term
        assign reset_hit[i] = term_s[i] && (input_terminal_function[i*prot_pkg::FN_W +:
            prot_pkg::FN_W] == prot_pkg::FN_FAULT_RESET);
        assign block_hit[i] = term_s[i] && (input_terminal_function[i*prot_pkg::FN_W +:
            prot_pkg::FN_W] == prot_pkg::FN_OUTPUT_BLOCK);
    end

    assign reset_level = (|reset_hit) || key_s;
    assign block_in = |block_hit;

    // ----------------------------------------------------------------
    // timers: undervoltage decision and block deceleration
    // ----------------------------------------------------------------
    tenth_timer_if uv_tmr ();
    tenth_timer_if dec_tmr ();
    tenth_timer #(.TICK_CYCLES(TICK_CYCLES)) u_uv_timer (.clk(clk), .rst_n(rst_n), .tmr(uv_tmr));
    tenth_timer #(.TICK_CYCLES(TICK_CYCLES)) u_dec_timer (.clk(clk), .rst_n(rst_n), .tmr(dec_tmr));

    // ----------------------------------------------------------------
    // trip latches
    // ----------------------------------------------------------------
    logic reset_prev_q, reset_prev_d;
    logic uv_prev_q, uv_prev_d;
    logic fan_trip_q, fan_trip_d;
    logic uv_trip_q, uv_trip_d;
    logic hot_trip_q, hot_trip_d;
    logic reset_pulse, fan_cause, uv_decided, fault_block;

    assign reset_pulse = reset_level && !reset_prev_q;
    assign fan_cause = fan_s && (fan_fault_mode == prot_pkg::FAN_MODE_TRIP);
    // the delay only postpones the recorded trip, never the blocking
    assign uv_decided = uv_s && uv_prev_q && uv_tmr.done;
    assign uv_tmr.start = uv_s && !uv_prev_q;
    assign uv_tmr.load = undervoltage_trip_delay;

    // set wins over reset, and a cause still present is not cleared
    always_comb begin
        reset_prev_d = reset_level;
        uv_prev_d = uv_s;
        fan_trip_d = fan_cause || (fan_trip_q && !reset_pulse);
        hot_trip_d = hot_s || (hot_trip_q && !reset_pulse);
        uv_trip_d = uv_decided || (uv_trip_q && !(reset_pulse && !uv_s));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_prev_q <= 1'b0;
            uv_prev_q <= 1'b0;
            fan_trip_q <= 1'b0;
            uv_trip_q <= 1'b0;
            hot_trip_q <= 1'b0;
        end else begin
            reset_prev_q <= reset_prev_d;
            uv_prev_q <= uv_prev_d;
            fan_trip_q <= fan_trip_d;
            uv_trip_q <= uv_trip_d;
            hot_trip_q <= hot_trip_d;
        end
    end

    // undervoltage blocks at once, before any trip is recorded
    assign fault_block = fan_trip_q || uv_trip_q || hot_trip_q || uv_s || hot_s;

    // ----------------------------------------------------------------
    // run, decelerate and block sequencing
    // ----------------------------------------------------------------
    prot_pkg::drive_state_t state_q, state_d;
    logic [prot_pkg::TIME_W-1:0] stop_time;
    logic [prot_pkg::MON_W-1:0] hold_f_q, hold_f_d, hold_i_q, hold_i_d;
    logic enable_q, enable_d, block_ind_q, block_ind_d, decel_q, decel_d;

    // out-of-range stop times are held to the top of the range
    assign stop_time = (block_stop_time > prot_pkg::BLOCK_STOP_MAX) ?
        prot_pkg::BLOCK_STOP_MAX : block_stop_time;
    assign dec_tmr.start = (state_q == prot_pkg::ST_RUN) && !fault_block && block_in &&
        (stop_time != prot_pkg::TIME_ZERO);
    assign dec_tmr.load = stop_time;

    always_comb begin
        state_d = state_q;
        hold_f_d = hold_f_q;
        hold_i_d = hold_i_q;
        case (state_q)
            prot_pkg::ST_STOPPED: begin
                if (run_s && !block_in && !fault_block) state_d = prot_pkg::ST_RUN;
            end
            prot_pkg::ST_RUN: begin
                if (block_in) begin
                    hold_f_d = output_frequency;
                    hold_i_d = output_current;
                    state_d = (stop_time == prot_pkg::TIME_ZERO || fault_block) ?
                        prot_pkg::ST_BLOCKED : prot_pkg::ST_DECEL;
                end else if (fault_block || !run_s) begin
                    state_d = prot_pkg::ST_STOPPED;
                end
            end
            prot_pkg::ST_DECEL: begin
                // too short a ramp may end in an overvoltage trip upstream
                if (fault_block) state_d = prot_pkg::ST_BLOCKED;
                else if (dec_tmr.done) state_d = prot_pkg::ST_BLOCKED;
            end
            prot_pkg::ST_BLOCKED: begin
                if (!block_in && run_s && !fault_block) state_d = prot_pkg::ST_RUN;
            end
            default: state_d = prot_pkg::ST_STOPPED;
        endcase
        enable_d = ((state_d == prot_pkg::ST_RUN) || (state_d == prot_pkg::ST_DECEL)) &&
            !fault_block;
        decel_d = (state_d == prot_pkg::ST_DECEL) && !fault_block;
        block_ind_d = (state_d == prot_pkg::ST_DECEL) || (state_d == prot_pkg::ST_BLOCKED);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= prot_pkg::ST_STOPPED;
            hold_f_q <= '0;
            hold_i_q <= '0;
            enable_q <= 1'b0;
            decel_q <= 1'b0;
            block_ind_q <= 1'b0;
        end else begin
            state_q <= state_d;
            hold_f_q <= hold_f_d;
            hold_i_q <= hold_i_d;
            enable_q <= enable_d;
            decel_q <= decel_d;
            block_ind_q <= block_ind_d;
        end
    end

    // ----------------------------------------------------------------
    // multi-function outputs
    // ----------------------------------------------------------------
    logic fan_warn, uv_warn;
    logic [prot_pkg::N_OUTPUTS*prot_pkg::FN_W-1:0] out_fn;
    logic [prot_pkg::N_OUTPUTS-1:0] mf_q, mf_d;

    assign fan_warn = fan_s && (fan_fault_mode == prot_pkg::FAN_MODE_WARNING);
    assign uv_warn = uv_s;
    assign out_fn = {transistor_output_function, relay_output_function};

    for (genvar k = 0; k < prot_pkg::N_OUTPUTS; k++) begin : g_out
        assign mf_d[k] =
            ((out_fn[k*prot_pkg::FN_W +: prot_pkg::FN_W] == prot_pkg::FN_FAN_WARNING) &&
             fan_warn) ||
            ((out_fn[k*prot_pkg::FN_W +: prot_pkg::FN_W] == prot_pkg::FN_UNDERVOLTAGE) &&
             uv_warn);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) mf_q <= '0;
        else mf_q <= mf_d;
    end

    assign relay_out = mf_q[1:0];
    assign transistor_out = mf_q[2];
    assign power_enable = enable_q;
    assign decelerating = decel_q;
    assign block_indication = block_ind_q;
    assign held_frequency = hold_f_q;
    assign held_current = hold_i_q;
    assign fan_trip = fan_trip_q;
    assign undervoltage_trip = uv_trip_q;
    assign overheat_trip = hot_trip_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    fan_trip_latch_a: assert property (fan_cause |=> fan_trip_q ##1 !power_enable)
        else $error("fan trip did not latch and block");
    fan_warn_only_a: assert property (fan_fault_mode && !fan_trip_q |=> !fan_trip_q)
        else $error("fan warning mode recorded a trip");
    fan_warn_out_a: assert property (
        fan_warn && out_fn[4:0] == prot_pkg::FN_FAN_WARNING |=> relay_out[0])
        else $error("fan warning missing on relay");
    overheat_block_a: assert property (hot_s |=> !power_enable && overheat_trip)
        else $error("overheat did not block");
    uv_block_a: assert property (uv_s |=> !power_enable)
        else $error("undervoltage did not block output");
    uv_delay_a: assert property (
        $rose(uv_s) && undervoltage_trip_delay != prot_pkg::TIME_ZERO && !uv_trip_q
        |=> !uv_trip_q [*2])
        else $error("undervoltage trip came before its delay");
    uv_warn_now_a: assert property (
        uv_s && transistor_output_function == prot_pkg::FN_UNDERVOLTAGE |=> transistor_out)
        else $error("undervoltage warning late");
    block_cut_a: assert property (
        state_q == prot_pkg::ST_RUN && block_in && stop_time == prot_pkg::TIME_ZERO
        |=> !power_enable && block_indication)
        else $error("block input did not cut output");
    hold_stable_a: assert property (
        state_q == prot_pkg::ST_BLOCKED |=> $stable(held_frequency) && $stable(held_current))
        else $error("held values changed while blocked");
    resume_gate_a: assert property (
        state_q == prot_pkg::ST_BLOCKED && (block_in || !run_s) |=> state_q != prot_pkg::ST_RUN)
        else $error("resumed without release and run");
    decel_start_a: assert property (
        state_q == prot_pkg::ST_RUN && block_in && !fault_block && stop_time != prot_pkg::TIME_ZERO
        |=> decelerating && power_enable)
        else $error("timed stop did not decelerate");
    reset_clear_a: assert property (
        reset_pulse && !uv_s && !fan_cause && !hot_s |=> !fan_trip_q && !uv_trip_q && !hot_trip_q)
        else $error("reset did not clear trips");
    uv_timer_run_a: assert property ($rose(uv_s) |=> uv_tmr.busy)
        else $error("undervoltage delay did not start");
    decel_timed_a: assert property (decelerating |-> dec_tmr.busy || dec_tmr.done)
        else $error("deceleration without a running ramp");
    decel_done_c: cover property (state_q == prot_pkg::ST_DECEL ##1 state_q == prot_pkg::ST_BLOCKED);
    resume_c: cover property (state_q == prot_pkg::ST_BLOCKED ##1 state_q == prot_pkg::ST_RUN);
    uv_trip_c: cover property ($rose(uv_trip_q));
    reset_c: cover property (uv_trip_q && reset_pulse);

endmodule : drive_protection_trip_control
`default_nettype wire

// file: rtl/prot_pkg.sv
package prot_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int unsigned N_TERMINALS = 8;
    localparam int unsigned N_OUTPUTS = 3; // relay 1, relay 2, transistor
    localparam int unsigned FN_W = 5;
    localparam int unsigned TIME_W = 16; // times in tenths of a second
    localparam int unsigned MON_W = 16;

    // ----------------------------------------------------------------
    // function codes of terminals and outputs
    // ----------------------------------------------------------------
    localparam logic [FN_W-1:0] FN_FAULT_RESET = 5'h03;
    localparam logic [FN_W-1:0] FN_OUTPUT_BLOCK = 5'h05;
    localparam logic [FN_W-1:0] FN_FAN_WARNING = 5'h08;
    localparam logic [FN_W-1:0] FN_UNDERVOLTAGE = 5'h0B;

    // ----------------------------------------------------------------
    // modes and limits
    // ----------------------------------------------------------------
    localparam logic FAN_MODE_TRIP = 1'b0;
    localparam logic FAN_MODE_WARNING = 1'b1;
    localparam logic [TIME_W-1:0] BLOCK_STOP_MAX = 16'h1770; // 600.0 s
    localparam logic [TIME_W-1:0] TIME_ZERO = 16'h0000;      // free-run / no delay

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned TIME_STEP_NS = 100_000_000; // 0.1 s
    localparam int unsigned TICK_CYCLES = TIME_STEP_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_STOPPED,
        ST_RUN,
        ST_DECEL,
        ST_BLOCKED
    } drive_state_t;

endpackage : prot_pkg

// file: rtl/tenth_timer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tenth_timer_if;
    logic start;
    logic [prot_pkg::TIME_W-1:0] load;
    logic done;
    logic busy;

    modport timer (input start, input load, output done, output busy);
    modport user (output start, output load, input done, input busy);
endinterface : tenth_timer_if
`default_nettype wire

// file: rtl/tenth_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tenth_timer #(
    parameter int unsigned TICK_CYCLES = prot_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    tenth_timer_if.timer tmr
);

    logic [31:0] pre_q, pre_d;
    logic [prot_pkg::TIME_W-1:0] cnt_q, cnt_d;
    logic busy_q, busy_d;
    logic done_q, done_d;

    // ----------------------------------------------------------------
    // down counter in tenths, restartable at any time
    // ----------------------------------------------------------------
    always_comb begin
        pre_d = pre_q;
        cnt_d = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (tmr.start) begin
            cnt_d = tmr.load;
            pre_d = 32'h0000_0000;
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (cnt_q == prot_pkg::TIME_ZERO) begin
                busy_d = 1'b0;
                done_d = 1'b1; // zero load ends on the next cycle
            end else if (pre_q == 32'(TICK_CYCLES - 1)) begin
                pre_d = 32'h0000_0000;
                cnt_d = cnt_q - 16'h0001;
            end else begin
                pre_d = pre_q + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 32'h0000_0000;
            cnt_q <= 16'h0000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign tmr.done = done_q;
    assign tmr.busy = busy_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    done_after_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
        done_q |-> $past(busy_q) && !busy_q)
        else $error("timer done without a running count");

endmodule : tenth_timer
`default_nettype wire

// file: testbench/controller_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far-side controller: terminal pins, run command, keypad key
// ----------------------------------------
module controller_model (
    // clock
    input wire logic clk,
    // pins towards the drive
    output logic [prot_pkg::N_TERMINALS-1:0] input_terminal,
    output logic run_command,
    output logic keypad_stop_reset
);
    // everything idles low until the bench asks for a change
    initial begin
        input_terminal = 8'h00;
        run_command = 1'h0;
        keypad_stop_reset = 1'h0;
    end

    // changes land 1 ns after the rising edge, never on it
    task automatic set_run(input logic v);
        @(posedge clk);
        #1 run_command = v;
    endtask : set_run

    task automatic set_pin(input int idx, input logic v);
        @(posedge clk);
        #1 input_terminal[idx] = v;
    endtask : set_pin

    // a clean rising edge, then a low gap longer than the synchroniser
    task automatic pulse_reset(input int idx, input logic use_key);
        @(posedge clk);
        #1;
        if (use_key) begin
            keypad_stop_reset = 1'h1;
        end else begin
            input_terminal[idx] = 1'h1;
        end
        repeat (3) @(posedge clk);
        #1;
        keypad_stop_reset = 1'h0;
        input_terminal[idx] = 1'h0;
        repeat (3) @(posedge clk);
        // leave off the edge so the caller samples settled outputs
        #1;
    endtask : pulse_reset
endmodule : controller_model
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // short tick keeps tenth-second delays to a few dozen cycles
    localparam int unsigned TICKS = 10;
    logic clk, rst_n, fan_error, dc_undervoltage, over_temperature, fan_fault_mode;
    logic [prot_pkg::N_TERMINALS*prot_pkg::FN_W-1:0] term_fn;
    logic [2*prot_pkg::FN_W-1:0] relay_fn;
    logic [prot_pkg::FN_W-1:0] q_fn;
    logic [15:0] uv_delay, stop_time, freq, cur, f, c;
    logic power_enable, decelerating, block_indication, transistor_out;
    logic fan_trip, undervoltage_trip, overheat_trip, run_command, keypad_stop_reset;
    logic [15:0] held_frequency, held_current;
    logic [1:0] relay_out;
    logic [7:0] input_terminal;
    int num_errors = 0;
    int samples_checked = 0;
    int blk, rsp, d, n;

    always #2 clk = ~clk;

    // ----------------------------------------
    // design and far side
    // ----------------------------------------
    drive_protection_trip_control #(.TICK_CYCLES(TICKS)) u_drive_protection_trip_control (
        .clk(clk), .rst_n(rst_n), .input_terminal(input_terminal),
        .run_command(run_command), .keypad_stop_reset(keypad_stop_reset),
        .fan_error(fan_error), .dc_undervoltage(dc_undervoltage),
        .over_temperature(over_temperature), .fan_fault_mode(fan_fault_mode),
        .input_terminal_function(term_fn), .relay_output_function(relay_fn),
        .transistor_output_function(q_fn), .undervoltage_trip_delay(uv_delay),
        .block_stop_time(stop_time), .output_frequency(freq), .output_current(cur),
        .power_enable(power_enable), .decelerating(decelerating),
        .block_indication(block_indication), .held_frequency(held_frequency),
        .held_current(held_current), .relay_out(relay_out), .transistor_out(transistor_out),
        .fan_trip(fan_trip), .undervoltage_trip(undervoltage_trip),
        .overheat_trip(overheat_trip));

    controller_model u_controller (
        .clk(clk), .input_terminal(input_terminal),
        .run_command(run_command), .keypad_stop_reset(keypad_stop_reset));

    // ----------------------------------------
    // expectations, comparisons, waits
    // ----------------------------------------
    function automatic int expect_cycles(input int tenths);
        return tenths * TICKS;
    endfunction : expect_cycles

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val

    // sample 1 ns after the edge so registered outputs have landed
    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : settle

    // bounded poll; running out of cycles ends the run as a failure
    task automatic wait_bit(input int sel, input logic want, input int limit);
        n = 0;
        while ((sel == 0 ? undervoltage_trip : decelerating) !== want && n < limit) begin
            settle(1);
            n++;
        end
        if (n >= limit) begin
            num_errors++;
            $display("CHECK FAILED t=%0t wait ran out got=%h exp=%h", $time, n, limit);
            give_verdict();
        end
    endtask : wait_bit

    // run low then high, so a restart never rides on an old level
    task automatic start_run();
        u_controller.set_run(1'h0);
        settle(4);
        u_controller.set_run(1'h1);
        settle(5);
        check_bit(power_enable, 1'h1);
    endtask : start_run

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clk = 1'h0;
        rst_n = 1'h0;
        {fan_error, dc_undervoltage, over_temperature, fan_fault_mode} = 4'h0;
        uv_delay = prot_pkg::TIME_ZERO;
        stop_time = prot_pkg::TIME_ZERO;
        void'($urandom(3767));
        freq = 16'($urandom);
        cur = 16'($urandom);
        blk = $urandom_range(7, 0);
        rsp = (blk + 1 + $urandom_range(6, 0)) % 8;
        term_fn = '0;
        term_fn[blk*prot_pkg::FN_W +: prot_pkg::FN_W] = prot_pkg::FN_OUTPUT_BLOCK;
        term_fn[rsp*prot_pkg::FN_W +: prot_pkg::FN_W] = prot_pkg::FN_FAULT_RESET;
        relay_fn = {5'h00, prot_pkg::FN_FAN_WARNING};
        q_fn = prot_pkg::FN_UNDERVOLTAGE;
        settle(10);
        rst_n = 1'h1;

        // fan fault in trip mode, reset refused while the fan is still bad
        start_run();
        fan_error = 1'h1;
        settle(5);
        check_bit(power_enable, 1'h0);
        check_bit(fan_trip, 1'h1);
        u_controller.pulse_reset(rsp, 1'h1);
        check_bit(fan_trip, 1'h1);
        fan_error = 1'h0;
        settle(3);
        u_controller.pulse_reset(rsp, 1'h1);
        check_bit(fan_trip, 1'h0);
        $display("test fan trip done");

        // fan warning keeps running until overheat steps in
        fan_fault_mode = prot_pkg::FAN_MODE_WARNING;
        start_run();
        fan_error = 1'h1;
        settle(5);
        check_bit(relay_out[0], 1'h1);
        check_bit(relay_out[1], 1'h0);
        check_bit(power_enable, 1'h1);
        check_bit(fan_trip, 1'h0);
        over_temperature = 1'h1;
        settle(5);
        check_bit(power_enable, 1'h0);
        check_bit(overheat_trip, 1'h1);
        {fan_error, over_temperature} = 2'h0;
        settle(3);
        u_controller.pulse_reset(rsp, 1'h0);
        check_bit(overheat_trip, 1'h0);
        check_bit(relay_out[0], 1'h0);
        $display("test fan warning done");

        // undervoltage: output off and warning at once, trip after delay
        d = $urandom_range(3, 1);
        uv_delay = 16'(d);
        start_run();
        dc_undervoltage = 1'h1;
        settle(5);
        check_bit(power_enable, 1'h0);
        check_bit(transistor_out, 1'h1);
        check_bit(undervoltage_trip, 1'h0);
        wait_bit(0, 1'h1, expect_cycles(d) + 10);
        check_bit(1'(n + 5 >= expect_cycles(d)), 1'h1);
        check_bit(undervoltage_trip, 1'h1);
        dc_undervoltage = 1'h0;
        settle(3);
        check_bit(transistor_out, 1'h0);
        u_controller.pulse_reset(rsp, 1'h0);
        check_bit(undervoltage_trip, 1'h0);
        $display("test undervoltage done");

        // free-run block holds the values seen at entry
        start_run();
        f = freq;
        c = cur;
        u_controller.set_pin(blk, 1'h1);
        settle(5);
        check_bit(power_enable, 1'h0);
        check_bit(block_indication, 1'h1);
        freq = ~f;
        cur = ~c;
        settle(2);
        check_val(held_frequency, f);
        check_val(held_current, c);
        u_controller.set_run(1'h0);
        u_controller.set_pin(blk, 1'h0);
        settle(5);
        check_bit(power_enable, 1'h0);
        u_controller.set_run(1'h1);
        settle(5);
        check_bit(power_enable, 1'h1);
        check_bit(block_indication, 1'h0);
        $display("test free-run block done");

        // timed block: short stop time chosen for the light test load
        d = $urandom_range(3, 1);
        stop_time = 16'(d);
        u_controller.set_pin(blk, 1'h1);
        settle(5);
        check_bit(decelerating, 1'h1);
        check_bit(power_enable, 1'h1);
        check_bit(block_indication, 1'h1);
        wait_bit(1, 1'h0, expect_cycles(d) + 10);
        check_bit(1'(n + 5 >= expect_cycles(d)), 1'h1);
        check_bit(power_enable, 1'h0);
        u_controller.set_pin(blk, 1'h0);
        $display("test timed block done");
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
